// ===== design/cpu_status_word.sv
// Processor status word with condition code patterns and mode protection
//
// Contract
// - Bits 8-15 hold the running segment number
// - Refresh per instruction; push word on call/interrupt
// - Bit 0 is one when privileged
// - Mode changes only privileged; returns check saved mode
// - Bit 1 interrupt enable, privileged writes only
// - Return traps on user-altered saved interrupt enable
// - Bit 2 trap enable: any mode, kept on procedure return
// - Bit 3 set for non-NOP right stack op
// - User mode cannot alter bit 3
// - Bit 4 overflow, only from defining instructions
// - Trap enabled: trap instead; integer does both
// - Bit 5 records carry out of top bit
// - Condition code never takes value three
// - Sign pattern: positive, negative, zero codes
// - Character pattern: digits give greater code
// - Letters give equal, others give less
// - Compare pattern: greater, less, equal codes
// - I/O: no response less, completed equal
// - I/O not ready only for data moving ops
// - Privileged instructions and uncallable calls need privilege
//
// The plain strobed port and the register offsets are this design's own decisions.
`timescale 1ns/1ps
`default_nettype none

module cpu_status_word
  import status_word_pkg::*;
(
  input  wire logic              core_clk,   // 250 MHz core clock
  input  wire logic              rst,        // Synchronous reset, active high
  input  wire logic [ADDR_W-1:0] addr_i,     // Register index
  input  wire logic [15:0]       wdata_i,    // Register write data
  input  wire logic              wr_i,       // Register write strobe
  input  wire logic              rd_i,       // Register read strobe
  output logic      [15:0]       rdata_o,    // Read data, cycle after strobe
  input  wire exec_t             exec_i,     // Executed instruction report
  input  wire marker_t           mark_i,     // Call, interrupt and return traffic
  output logic      [15:0]       status_o,   // Live status word
  output logic      [15:0]       marker_o,   // Word to store in the marker
  output logic                   marker_v_o, // Marker word valid pulse
  output logic                   ovf_trap_o, // Trap to segment 1 pulse
  output logic                   ret_trap_o, // Return check failed pulse
  output logic                   priv_fault_o // Privilege violation pulse
);

  ////////////////////////////////////////////////////////////////////////////
  // Decoding helpers

  // Protected write: user mode may only touch the unprotected bits
  function automatic logic [15:0] guarded(input logic [15:0] cur,
                                          input logic [15:0] data,
                                          input logic [15:0] mask,
                                          input logic        user);
    logic [15:0] eff;
    eff = user ? (mask & USER_WR_MASK) : mask;
    return (cur & ~eff) | (data & eff);
  endfunction : guarded

  // Sign pattern
  function automatic cc_t cc_sign(input logic signed [15:0] v);
    if (v == 16'sh0000) return code_equal;
    else if (v < 16'sh0000) return code_less;
    else return code_greater;
  endfunction : cc_sign

  // Character class pattern on the low byte
  function automatic cc_t cc_char(input logic [7:0] b);
    if (b >= DIGIT_LO && b <= DIGIT_HI) return code_greater;
    else if ((b >= UPPER_LO && b <= UPPER_HI) ||
             (b >= LOWER_LO && b <= LOWER_HI)) return code_equal;
    else return code_less;
  endfunction : cc_char

  // Comparison pattern, signed operands
  function automatic cc_t cc_cmp(input logic signed [15:0] a,
                                 input logic signed [15:0] b);
    if (a == b) return code_equal;
    else if (a < b) return code_less;
    else return code_greater;
  endfunction : cc_cmp

  // I/O pattern; not-ready is only reported by data moving instructions
  function automatic cc_t cc_io(input io_resp_t r, input logic moves);
    unique case (r)
      io_no_response: return code_less;
      io_not_ready:   return moves ? code_greater : code_equal;
      io_ready:       return code_equal;
      default:        return code_equal;            // Spare encoding
    endcase
  endfunction : cc_io

  ////////////////////////////////////////////////////////////////////////////
  // State

  state_t st_q;  // All registered state
  state_t st_d;  // Next state

  logic        user;    // Running in user mode
  logic        fault;   // Instruction refused for lack of privilege
  logic        bad_ret; // Saved word fails the return checks
  logic [15:0] s;       // Working copy of the status word
  cc_t         cc;      // Condition code chosen by the pattern

  ////////////////////////////////////////////////////////////////////////////
  // Next state

  // One pass: software write, then return, else push plus instruction refresh
  always_comb begin
    st_d            = st_q;
    st_d.marker_v   = 1'b0;
    st_d.ovf_trap   = 1'b0;
    st_d.ret_trap   = 1'b0;
    st_d.priv_fault = 1'b0;
    st_d.rdata      = 16'h0000;
    s               = st_q.machine_status_word;
    cc              = cc_t'(st_q.machine_status_word[CC_HI:CC_LO]);
    user            = ~st_q.machine_status_word[MODE_BIT];
    fault           = exec_i.done && user && (exec_i.priv_instr || exec_i.uncallable);
    // User code may neither raise privilege nor change the enable in a saved word
    bad_ret         = user && (mark_i.ret_int || mark_i.saved[MODE_BIT] ||
                      (mark_i.saved[IEN_BIT] != st_q.machine_status_word[IEN_BIT]));

    // Register read answers one cycle later; unmapped indices read zero
    if (rd_i) begin
      unique case (addr_i)
        REG_STATUS: st_d.rdata = st_q.machine_status_word;
        REG_EVENTS: st_d.rdata = {{(16-EV_W){1'b0}}, st_q.events};
        default:    st_d.rdata = 16'h0000;
      endcase
    end

    // Software write goes through the same protection as an instruction
    if (wr_i && addr_i == REG_STATUS) begin
      s = guarded(s, wdata_i, 16'hFFFF, user);
    end

    if (mark_i.ret_req) begin
      // Returning restores the saved word unless the checks fail
      if (bad_ret) begin
        st_d.ret_trap = 1'b1;
      end else begin
        s = mark_i.saved;
        if (!mark_i.ret_int) begin
          s[UTRAP_BIT] = st_q.machine_status_word[UTRAP_BIT];
        end
      end
    end else begin
      // Suspension hands the pre-instruction word to the marker
      if (mark_i.push_req) begin
        st_d.marker   = st_q.machine_status_word;
        st_d.marker_v = 1'b1;
      end
      if (fault) begin
        // Refused instruction leaves the word as it was
        st_d.priv_fault = 1'b1;
      end else if (exec_i.done) begin
        // Register-set instruction, any mode for the trap enable
        if (exec_i.set_req) begin
          s = guarded(s, exec_i.set_data, exec_i.set_mask, user);
        end
        // Pending right stack op marks a resumable half-done pair
        s[RSOP_BIT] = exec_i.stack_pair && (exec_i.right_op != NOP_CODE);
        // Overflow, subject to the user trap enable
        if (exec_i.ovf_valid) begin
          if (exec_i.ovf_cond && st_q.machine_status_word[UTRAP_BIT]) begin
            st_d.ovf_trap = 1'b1;
            s[OVF_BIT]    = exec_i.ovf_int;
          end else begin
            s[OVF_BIT]    = exec_i.ovf_cond;
          end
        end
        // Carry out of the top bit
        if (exec_i.carry_valid) begin
          s[CARRY_BIT] = exec_i.carry;
        end
        // Condition code from the selected pattern
        unique case (exec_i.pattern)
          // Keep means the working copy, so a register-set code survives
          cc_keep:             cc = cc_t'(s[CC_HI:CC_LO]);
          sign_pattern:        cc = cc_sign(exec_i.op_a);
          char_class_pattern:  cc = cc_char(exec_i.op_a[7:0]);
          compare_pattern:     cc = cc_cmp(exec_i.op_a, exec_i.op_b);
          io_response_pattern: cc = cc_io(exec_i.io_resp, exec_i.io_moves_data);
          default:             cc = cc_t'(s[CC_HI:CC_LO]);
        endcase
        // A stale third code is never carried forward
        s[CC_HI:CC_LO] = (cc == 2'h3) ? code_equal : cc;
        // Entering a new segment records its number
        if (exec_i.seg_load) begin
          s[SEG_HI:SEG_LO] = exec_i.seg_num;
        end
      end
    end
    // Software writes and saved words may carry the unused fourth code
    if (s[CC_HI:CC_LO] == 2'h3) begin
      s[CC_HI:CC_LO] = code_equal;
    end
    st_d.machine_status_word = s;

    // Sticky flags: a new event wins over a clear in the same cycle
    if (wr_i && addr_i == REG_EVENTS) begin
      st_d.events = st_q.events & ~wdata_i[EV_W-1:0];
    end
    st_d.events[EV_OVF_TRAP]   = st_d.events[EV_OVF_TRAP]   | st_d.ovf_trap;
    st_d.events[EV_RET_TRAP]   = st_d.events[EV_RET_TRAP]   | st_d.ret_trap;
    st_d.events[EV_PRIV_FAULT] = st_d.events[EV_PRIV_FAULT] | st_d.priv_fault;
  end

  ////////////////////////////////////////////////////////////////////////////
  // Registers

  // Single state register; reset gives privileged mode and quiet outputs
  always_ff @(posedge core_clk) begin
    if (rst) begin
      st_q <= '{machine_status_word: STATUS_RESET, marker: 16'h0000, rdata: 16'h0000,
                events: '0, default: 1'b0};
    end else begin
      st_q <= st_d;
    end
  end

  // Outputs come straight from the state register
  assign status_o     = st_q.machine_status_word;
  assign marker_o     = st_q.marker;
  assign marker_v_o   = st_q.marker_v;
  assign ovf_trap_o   = st_q.ovf_trap;
  assign ret_trap_o   = st_q.ret_trap;
  assign priv_fault_o = st_q.priv_fault;
  assign rdata_o      = st_q.rdata;

  ////////////////////////////////////////////////////////////////////////////
  // Checks

  default clocking cb @(posedge core_clk); endclocking
  default disable iff (rst);

  // Plain instruction completion with no return or refusal
  sequence s_plain_done;
    exec_i.done && !mark_i.ret_req && !fault && !(wr_i && addr_i == REG_STATUS);
  endsequence

  property p_seg_load;
    s_plain_done and exec_i.seg_load |=> status_o[SEG_HI:SEG_LO] == $past(exec_i.seg_num);
  endproperty
  a_seg_load: assert property (p_seg_load) else $error("segment number not loaded");

  property p_marker_push;
    mark_i.push_req && !mark_i.ret_req |=> marker_v_o && marker_o == $past(status_o);
  endproperty
  a_marker_push: assert property (p_marker_push) else $error("marker word wrong");

  property p_user_mode_sticks;
    !status_o[MODE_BIT] && !mark_i.ret_req |=> !status_o[MODE_BIT];
  endproperty
  a_user_mode_sticks: assert property (p_user_mode_sticks) else $error("user raised privilege");

  property p_user_ien_hold;
    !status_o[MODE_BIT] && !mark_i.ret_req |=> $stable(status_o[IEN_BIT]);
  endproperty
  a_user_ien_hold: assert property (p_user_ien_hold) else $error("user changed enable");

  property p_ret_trap;
    mark_i.ret_req && !status_o[MODE_BIT] && !mark_i.ret_int &&
      (mark_i.saved[IEN_BIT] != status_o[IEN_BIT])
      |=> ret_trap_o ##1 (!ret_trap_o || $past(mark_i.ret_req));
  endproperty
  a_ret_trap: assert property (p_ret_trap) else $error("altered enable not trapped");

  property p_utrap_kept;
    mark_i.ret_req && !mark_i.ret_int && !(wr_i && addr_i == REG_STATUS)
      |=> status_o[UTRAP_BIT] == $past(status_o[UTRAP_BIT]);
  endproperty
  a_utrap_kept: assert property (p_utrap_kept) else $error("return changed trap enable");

  property p_rsop;
    s_plain_done |=> status_o[RSOP_BIT] ==
      ($past(exec_i.stack_pair) && $past(exec_i.right_op) != NOP_CODE);
  endproperty
  a_rsop: assert property (p_rsop) else $error("right op flag wrong");

  property p_ovf_trap;
    s_plain_done and (exec_i.ovf_valid && exec_i.ovf_cond && status_o[UTRAP_BIT])
      |=> ovf_trap_o && status_o[OVF_BIT] == $past(exec_i.ovf_int);
  endproperty
  a_ovf_trap: assert property (p_ovf_trap) else $error("overflow trap wrong");

  property p_cc_legal;
    status_o[CC_HI:CC_LO] != 2'h3;
  endproperty
  a_cc_legal: assert property (p_cc_legal) else $error("illegal condition code");

  property p_char_digit;
    s_plain_done and (exec_i.pattern == char_class_pattern) and
      (exec_i.op_a[7:0] >= DIGIT_LO && exec_i.op_a[7:0] <= DIGIT_HI)
      |=> status_o[CC_HI:CC_LO] == code_greater;
  endproperty
  a_char_digit: assert property (p_char_digit) else $error("digit code wrong");

  property p_priv_fault;
    exec_i.done && !status_o[MODE_BIT] && exec_i.priv_instr && !mark_i.ret_req
      |=> priv_fault_o && $stable(status_o);
  endproperty
  a_priv_fault: assert property (p_priv_fault) else $error("privilege fault missed");

endmodule : cpu_status_word

`default_nettype wire

// ===== design/status_word_pkg.sv
// Constants, types and carriers shared by the processor status word logic
package status_word_pkg;

  // Register port map, word indices on the plain register port
  localparam int          ADDR_W        = 2;
  localparam logic [1:0]  REG_STATUS    = 2'h0;  // Live status word
  localparam logic [1:0]  REG_EVENTS    = 2'h1;  // Sticky event flags, write 1 to clear

  // Status word field positions
  localparam int          MODE_BIT      = 0;   // 1 = privileged
  localparam int          IEN_BIT       = 1;   // External interrupt enable
  localparam int          UTRAP_BIT     = 2;   // User trap enable
  localparam int          RSOP_BIT      = 3;   // Right stack op pending
  localparam int          OVF_BIT       = 4;   // Overflow
  localparam int          CARRY_BIT     = 5;   // Carry
  localparam int          CC_LO         = 6;   // Condition code, low bit
  localparam int          CC_HI         = 7;   // Condition code, high bit
  localparam int          SEG_LO        = 8;   // Code segment number, low bit
  localparam int          SEG_HI        = 15;  // Code segment number, high bit

  // Reset value: privileged, everything else clear, segment 0
  localparam logic [15:0] STATUS_RESET  = 16'h0001;
  // Bits a user-mode write may touch: trap enable, overflow, carry, code
  localparam logic [15:0] USER_WR_MASK  = 16'h00F4;
  // Right stack op code that means no operation
  localparam logic [5:0]  NOP_CODE      = 6'h00;

  // Event flag positions
  localparam int          EV_OVF_TRAP   = 0;
  localparam int          EV_RET_TRAP   = 1;
  localparam int          EV_PRIV_FAULT = 2;
  localparam int          EV_W          = 3;

  // Character class bounds (digits, upper and lower letters)
  localparam logic [7:0]  DIGIT_LO      = 8'h30;
  localparam logic [7:0]  DIGIT_HI      = 8'h39;
  localparam logic [7:0]  UPPER_LO      = 8'h41;
  localparam logic [7:0]  UPPER_HI      = 8'h5A;
  localparam logic [7:0]  LOWER_LO      = 8'h61;
  localparam logic [7:0]  LOWER_HI      = 8'h7A;

  // Condition code encodings; the fourth code is never produced
  typedef enum logic [1:0] {
    code_greater = 2'h0,
    code_less    = 2'h1,
    code_equal   = 2'h2
  } cc_t;

  // Which pattern sets the condition code for an instruction
  typedef enum logic [2:0] {
    cc_keep             = 3'h0,
    sign_pattern        = 3'h1,
    char_class_pattern  = 3'h2,
    compare_pattern     = 3'h3,
    io_response_pattern = 3'h4
  } cc_pattern_t;

  // Outcome of an I/O instruction
  typedef enum logic [1:0] {
    io_ready       = 2'h0,
    io_not_ready   = 2'h1,
    io_no_response = 2'h2
  } io_resp_t;

  // One executed instruction as reported by the sequencer
  typedef struct packed {
    logic               done;          // Instruction completed this cycle
    logic               priv_instr;    // Instruction is privileged
    logic               uncallable;    // Call targets an uncallable segment
    cc_pattern_t        pattern;       // Condition code pattern
    logic signed [15:0] op_a;          // Operand 1 (or the only operand)
    logic signed [15:0] op_b;          // Operand 2
    io_resp_t           io_resp;       // I/O answer
    logic               io_moves_data; // Write, read or start I/O kind
    logic               ovf_valid;     // Instruction defines overflow
    logic               ovf_cond;      // Overflow or underflow occurred
    logic               ovf_int;       // Overflow is integer kind
    logic               carry_valid;   // Instruction defines carry
    logic               carry;         // Carry out of the top bit
    logic               stack_pair;    // Left half of a stack op pair ran
    logic [5:0]         right_op;      // Right stack op field
    logic               seg_load;      // Control moved to a new segment
    logic [7:0]         seg_num;       // New segment number
    logic               set_req;       // Register-set instruction
    logic [15:0]        set_mask;      // Bits it wants to change
    logic [15:0]        set_data;      // Values for those bits
  } exec_t;

  // Stack marker traffic: push on call or interrupt, pop on return
  typedef struct packed {
    logic        push_req;  // Call or interrupt suspends the segment
    logic        ret_req;   // Return restores a saved word
    logic        ret_int;   // Return from interrupt rather than procedure
    logic [15:0] saved;     // Saved word from the marker
  } marker_t;

  // Whole state of the block
  typedef struct packed {
    logic [15:0]     machine_status_word;        // Live status word
    logic [15:0]     marker;     // Word handed to the stack marker
    logic            marker_v;   // Marker word valid pulse
    logic            ovf_trap;   // Trap to segment 1 pulse
    logic            ret_trap;   // Illegal saved-word change pulse
    logic            priv_fault; // Privilege violation pulse
    logic [EV_W-1:0] events;     // Sticky copies of the three trap and fault pulses
    logic [15:0]     rdata;      // Register read data
  } state_t;

endpackage : status_word_pkg

// ===== tb/tb_cpu_status_word.sv
// Self-checking bench for the processor status word block
`timescale 1ns/1ps
`default_nettype none

module tb_cpu_status_word
  import status_word_pkg::*;
;
  ////////////////////////////////////////////////////////////////////////////////
  // Expected result of one request: status, read data, marker, pulses
  typedef struct packed {
    logic [15:0] st;
    logic [15:0] rd;
    logic [15:0] mk;
    logic [3:0]  pl;  // Marker valid, overflow trap, return trap, privilege fault
  } note_t;

  logic              core_clk = 1'b0;  // 250 MHz
  logic              rst      = 1'b1;  // Synchronous, active high
  logic [ADDR_W-1:0] addr_i   = '0;
  logic [15:0]       wdata_i  = '0;
  logic              wr_i     = 1'b0;
  logic              rd_i     = 1'b0;
  exec_t             exec_i   = '0;
  marker_t           mark_i   = '0;
  logic [15:0]       rdata_o, status_o, marker_o;
  logic              marker_v_o, ovf_trap_o, ret_trap_o, priv_fault_o;
  note_t             notes[$];          // Expectations in request order
  logic              seen_q   = 1'b0;   // A request was taken last edge
  logic [15:0]       exp_sta  = STATUS_RESET;
  logic [2:0]        exp_ev   = '0;
  int                n_fail = 0, comparisons = 0, seed = 2753;

  always #2 core_clk = ~core_clk;

  cpu_status_word DUT (.core_clk(core_clk), .rst(rst), .addr_i(addr_i), .wdata_i(wdata_i),
    .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o), .exec_i(exec_i), .mark_i(mark_i),
    .status_o(status_o), .marker_o(marker_o), .marker_v_o(marker_v_o),
    .ovf_trap_o(ovf_trap_o), .ret_trap_o(ret_trap_o), .priv_fault_o(priv_fault_o));

  ////////////////////////////////////////////////////////////////////////////////
  // Compare and count; four-state compare, so an unknown matches only the same unknown
  task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
    comparisons++;
    if (seen !== exp) begin
      n_fail++;
      $display("Error %s expected %h seen %h", what, exp, seen);
    end
  endtask : check

  task automatic complete_run();
    $display("Counts: %0d comparisons, %0d mismatches", comparisons, n_fail);
    if (n_fail == 0 && comparisons > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask : complete_run

  ////////////////////////////////////////////////////////////////////////////////
  // Drive one cycle of requests and note the expected outcome from the rules
  task automatic issue(input logic w, input logic r, input logic [1:0] a,
                       input logic [15:0] d, input exec_t e, input marker_t k);
    note_t       n;
    logic [15:0] msk;
    logic [7:0]  c;
    n = '0;
    @(posedge core_clk);
    wr_i <= w; rd_i <= r; addr_i <= a; wdata_i <= d; exec_i <= e; mark_i <= k;
    // Register write lands first; user writes only reach the open bits
    if (w && a == REG_STATUS) exp_sta = exp_sta[0] ? d : ((exp_sta & ~16'h00F4) | (d & 16'h00F4));
    if (w && a == REG_EVENTS) exp_ev = exp_ev & ~d[2:0];
    if (r) n.rd = (a == REG_STATUS) ? exp_sta : (a == REG_EVENTS) ? {13'h0000, exp_ev} : 16'h0000;
    if (k.ret_req) begin
      // Return: user mode may not bring back privilege or a changed enable
      if (!exp_sta[0] && (k.ret_int || k.saved[0] || k.saved[1] != exp_sta[1])) begin
        n.pl[1] = 1'b1;
        exp_ev[1] = 1'b1;
      end else begin
        exp_sta = k.ret_int ? k.saved : {k.saved[15:3], exp_sta[2], k.saved[1:0]};
      end
    end else begin
      if (k.push_req) begin
        n.pl[3] = 1'b1;
        n.mk = exp_sta;
      end
      if (e.done && !exp_sta[0] && (e.priv_instr || e.uncallable)) begin
        n.pl[0] = 1'b1;
        exp_ev[2] = 1'b1;
      end else if (e.done) begin
        msk = e.set_mask & (exp_sta[0] ? 16'hFFFF : 16'h00F4);
        if (e.set_req) exp_sta = (exp_sta & ~msk) | (e.set_data & msk);
        exp_sta[3] = e.stack_pair && e.right_op != 6'h00;
        if (e.ovf_valid && exp_sta[2] && e.ovf_cond) begin
          n.pl[2] = 1'b1;
          exp_ev[0] = 1'b1;
          exp_sta[4] = e.ovf_int;
        end else if (e.ovf_valid) exp_sta[4] = e.ovf_cond;
        if (e.carry_valid) exp_sta[5] = e.carry;
        c = e.op_a[7:0];
        case (e.pattern)
          sign_pattern: exp_sta[7:6] = ($signed(e.op_a) > 0) ? 2'h0 : ($signed(e.op_a) < 0) ? 2'h1 : 2'h2;
          compare_pattern: exp_sta[7:6] = ($signed(e.op_a) > $signed(e.op_b)) ? 2'h0 :
                             ($signed(e.op_a) < $signed(e.op_b)) ? 2'h1 : 2'h2;
          char_class_pattern: exp_sta[7:6] = (c >= 8'h30 && c <= 8'h39) ? 2'h0 :
                             ((c >= 8'h41 && c <= 8'h5A) || (c >= 8'h61 && c <= 8'h7A)) ? 2'h2 : 2'h1;
          io_response_pattern: exp_sta[7:6] = (e.io_resp == io_no_response) ? 2'h1 :
                             (e.io_resp == io_not_ready && e.io_moves_data) ? 2'h0 : 2'h2;
          default: ;
        endcase
        if (e.seg_load) exp_sta[15:8] = e.seg_num;
      end
    end
    // The fourth code never reaches the live word
    if (exp_sta[7:6] == 2'h3) exp_sta[7:6] = 2'h2;
    n.st = exp_sta;
    if (w || r || e.done || k.push_req || k.ret_req) notes.push_back(n);
  endtask : issue

  task automatic ex(input exec_t e);
    issue(1'b0, 1'b0, 2'h0, 16'h0000, e, '0);
  endtask : ex

  ////////////////////////////////////////////////////////////////////////////////
  // Watch outputs the cycle after each taken request
  always @(posedge core_clk) begin
    seen_q <= !rst && (wr_i || rd_i || exec_i.done || mark_i.push_req || mark_i.ret_req);
  end

  always @(negedge core_clk) begin
    note_t n;
    if (seen_q && notes.size() == 0) begin
      n_fail++;
      $display("Error notes expected entry seen empty");
    end else if (seen_q) begin
      n = notes.pop_front();
      check("status", status_o, n.st);
      check("rdata", rdata_o, n.rd);
      check("pulses", {12'h000, marker_v_o, ovf_trap_o, ret_trap_o, priv_fault_o}, {12'h000, n.pl});
      if (n.pl[3]) check("marker", marker_o, n.mk);
    end
  end

  // Hang guard
  initial begin
    repeat (20000) @(posedge core_clk);
    n_fail++;
    $display("Error watchdog expected end seen hang");
    complete_run();
  end

  ////////////////////////////////////////////////////////////////////////////////
  initial begin
    exec_t   e;
    marker_t k;
    repeat (4) @(posedge core_clk);
    rst <= 1'b0;
    issue(1'b0, 1'b1, REG_STATUS, 16'h0000, '0, '0);
    issue(1'b0, 1'b1, 2'h2, 16'h0000, '0, '0);
    $display("Test reset done");
    // Sign boundaries then random, compare random with ties, all 256 low bytes, all I/O answers
    for (int i = 0; i < 24; i++) begin
      e = '0; e.done = 1'b1; e.pattern = sign_pattern;
      e.op_a = (i == 0) ? 16'h0000 : (i == 1) ? 16'h8000 : (i == 2) ? 16'h7FFF : 16'($random(seed));
      ex(e);
      e.pattern = compare_pattern; e.op_b = 16'($random(seed));
      if (i % 4 == 0) e.op_a = e.op_b;
      ex(e);
    end
    for (int c = 0; c < 256; c++) begin
      e = '0; e.done = 1'b1; e.pattern = char_class_pattern;
      e.op_a = {8'($random(seed)), c[7:0]};
      ex(e);
    end
    for (int r = 0; r < 3; r++) begin
      for (int mv = 0; mv < 2; mv++) begin
        e = '0; e.done = 1'b1; e.pattern = io_response_pattern;
        e.io_resp = io_resp_t'(r); e.io_moves_data = mv[0];
        ex(e);
      end
    end
    $display("Test condition codes done");
    // Stack op flag, segment number, marker push
    e = '0; e.done = 1'b1; e.stack_pair = 1'b1; e.right_op = 6'h2A; e.seg_load = 1'b1;
    e.seg_num = 8'($random(seed));
    ex(e);
    e.right_op = 6'h00; e.seg_load = 1'b0;
    ex(e);
    k = '0; k.push_req = 1'b1;
    issue(1'b0, 1'b0, 2'h0, 16'h0000, '0, k);
    // Overflow and carry, traps off then on
    e = '0; e.done = 1'b1; e.ovf_valid = 1'b1; e.ovf_cond = 1'b1; e.carry_valid = 1'b1; e.carry = 1'b1;
    ex(e);
    issue(1'b1, 1'b0, REG_STATUS, exp_sta | 16'h0004, '0, '0);
    ex(e);
    e.ovf_int = 1'b1; e.carry = 1'b0;
    ex(e);
    issue(1'b0, 1'b1, REG_EVENTS, 16'h0000, '0, '0);
    issue(1'b1, 1'b0, REG_EVENTS, 16'h0007, '0, '0);
    issue(1'b0, 1'b1, REG_EVENTS, 16'h0000, '0, '0);
    $display("Test indicators done");
    // Drop to user mode, then try every protected path
    issue(1'b1, 1'b0, REG_STATUS, 16'h000E, '0, '0);
    issue(1'b1, 1'b0, REG_STATUS, 16'hFFF1, '0, '0);
    e = '0; e.done = 1'b1; e.set_req = 1'b1; e.set_mask = 16'hFFFF; e.set_data = 16'h0001;
    ex(e);
    e = '0; e.done = 1'b1; e.priv_instr = 1'b1; e.pattern = sign_pattern; e.op_a = 16'h0005;
    ex(e);
    e.priv_instr = 1'b0; e.uncallable = 1'b1;
    ex(e);
    k = '0; k.ret_req = 1'b1; k.saved = exp_sta ^ 16'h0002;
    issue(1'b0, 1'b0, 2'h0, 16'h0000, '0, k);
    k.saved = exp_sta | 16'h0001;
    issue(1'b0, 1'b0, 2'h0, 16'h0000, '0, k);
    k.saved = exp_sta; k.ret_int = 1'b1;
    issue(1'b0, 1'b0, 2'h0, 16'h0000, '0, k);
    k.saved = exp_sta ^ 16'hAB04; k.ret_int = 1'b0;
    issue(1'b0, 1'b0, 2'h0, 16'h0000, '0, k);
    issue(1'b0, 1'b1, REG_EVENTS, 16'h0000, '0, '0);
    issue(1'b0, 1'b0, 2'h0, 16'h0000, '0, '0);
    $display("Test protection done");
    // Second reset brings back privilege, then a legal interrupt return
    rst <= 1'b1;
    repeat (2) @(posedge core_clk);
    rst <= 1'b0;
    exp_sta = STATUS_RESET;
    exp_ev  = '0;
    issue(1'b0, 1'b1, REG_STATUS, 16'h0000, '0, '0);
    k = '0;
    k.ret_req = 1'b1;
    k.ret_int = 1'b1;
    k.saved = 16'h5A05;
    issue(1'b0, 1'b0, 2'h0, 16'h0000, '0, k);
    issue(1'b0, 1'b1, REG_EVENTS, 16'h0000, '0, '0);
    issue(1'b0, 1'b0, 2'h0, 16'h0000, '0, '0);
    $display("Test second reset done");
    repeat (3) @(posedge core_clk);
    if (notes.size() != 0) begin
      n_fail++;
      $display("Error notes expected empty seen %0d", notes.size());
    end
    complete_run();
  end

endmodule : tb_cpu_status_word

`default_nettype wire
